/* rtl/link_cfg_pkg.sv */
// Constants, register map and character codes for the link test block
package link_cfg_pkg;
	// APB register map: printed offsets are indices, byte address = 4*index
	localparam int          ADDR_W      = 14;
	localparam int          DATA_W      = 32;
	localparam logic [11:0] IDX_TEST    = 12'h205;
	localparam logic [11:0] IDX_IDENT   = 12'h206;
	localparam logic [11:0] IDX_COMMA   = 12'h207;
	localparam logic [13:0] ADDR_TEST   = {IDX_TEST, 2'b00};
	localparam logic [13:0] ADDR_IDENT  = {IDX_IDENT, 2'b00};
	localparam logic [13:0] ADDR_COMMA  = {IDX_COMMA, 2'b00};
	localparam logic [7:0]  RST_TEST    = 8'h00;
	localparam logic [7:0]  RST_IDENT   = 8'h00;
	localparam logic [7:0]  RST_COMMA   = 8'h00;
	localparam int          TEST_SEL_W  = 5;
	localparam int          COMMA_W     = 2;
	localparam int          REG_W       = 8;

	// Test select codes
	localparam logic [4:0] TP_NORMAL    = 5'h00;
	localparam logic [4:0] TP_PRBS7     = 5'h01;
	localparam logic [4:0] TP_PRBS15    = 5'h02;
	localparam logic [4:0] TP_PRBS23    = 5'h03;
	localparam logic [4:0] TP_RAMP      = 5'h04;
	localparam logic [4:0] TP_TRANSPORT = 5'h05;
	localparam logic [4:0] TP_D21_5     = 5'h06;
	localparam logic [4:0] TP_K28_5     = 5'h07;
	localparam logic [4:0] TP_ILA_LOOP  = 5'h08;
	localparam logic [4:0] TP_RPAT      = 5'h09;
	localparam logic [4:0] TP_LOW       = 5'h0a;
	localparam logic [4:0] TP_HIGH      = 5'h0b;
	localparam logic [4:0] TP_RSVD      = 5'h0c;
	localparam logic [4:0] TP_PRBS9     = 5'h0d;
	localparam logic [4:0] TP_PRBS31    = 5'h0e;
	localparam logic [4:0] TP_CLOCK     = 5'h0f;
	localparam logic [4:0] TP_K28_7     = 5'h10;

	// Frame comma select codes
	localparam logic [1:0] FC_K28_7     = 2'h0;
	localparam logic [1:0] FC_K28_1     = 2'h1;
	localparam logic [1:0] FC_K28_5     = 2'h2;

	// Octet codes
	localparam logic [7:0] K28_0        = 8'h1c;
	localparam logic [7:0] K28_1        = 8'h3c;
	localparam logic [7:0] K28_3        = 8'h7c;
	localparam logic [7:0] K28_4        = 8'h9c;
	localparam logic [7:0] K28_5        = 8'hbc;
	localparam logic [7:0] K28_7        = 8'hfc;
	localparam logic [7:0] D21_5        = 8'hb5;
	localparam logic [7:0] OCT_ZERO     = 8'h00;
	localparam logic [15:0] CLOCK_WORD  = 16'h00ff;
	localparam logic [15:0] WORD_LOW    = 16'h0000;
	localparam logic [15:0] WORD_HIGH   = 16'hffff;
	localparam logic [15:0] RPAT_SEQ [4] = '{16'hbe_d7, 16'h23_47,
		16'h6b_8f, 16'hb3_14};

	// Lane word and alignment sequence shape
	localparam int         WORD_W       = 16;
	localparam int         LANE_W       = WORD_W + 2;
	localparam int         LFSR_W       = 31;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7fffffff;
	localparam logic [1:0] ILA_LAST_W   = 2'h3;
	localparam logic [1:0] ILA_ID_MF    = 2'h1;
	localparam logic [1:0] ILA_ID_W     = 2'h1;
	localparam logic [3:0] ILA_END      = 4'hf;
	localparam int         BUF_DEPTH    = 2;

	typedef enum logic [1:0] {st_off, st_ila, st_run} link_state_t;
endpackage

/* rtl/link_test_framing.sv */
// Link test pattern, alignment identifier and frame comma configuration
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Test select 0 gives data, 1..6 give PRBS7/15/23, ramp, transport, D21.5.
// - Select 7 K28.5, 8 repeated alignment, 9 RPAT, 10 lanes low, 11 high.
// - Select 13 PRBS9, 14 PRBS31, 15 clock 0x00FF, 16 K28.7; rest reserved.
// - K28.5, repeated alignment, RPAT and K28.7 need 8b/10b encoding.
// - The identifier goes out in the second alignment multiframe.
// - Link A sends the identifier, link B sends it plus one.
// - Identifier bit 0 is always stored and read as zero.
// - Comma select 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - The comma replaces a repeated frame-end octet, in 8b/10b only.
//
// The APB interface to the registers was left to the implementer.
module link_test_framing
	import link_cfg_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Link control from elsewhere
	input  wire logic              link_enable,
	input  wire logic              enc_8b10b,
	// Sample word input
	input  wire logic              sample_valid,
	output logic                   sample_ready,
	input  wire logic [WORD_W-1:0] sample_data,
	input  wire logic              sample_frame_end,
	// Lane word output, both links
	output logic                   lane_valid,
	input  wire logic              lane_ready,
	output logic      [WORD_W-1:0] lane_a_data,
	output logic      [1:0]        lane_a_is_k,
	output logic      [WORD_W-1:0] lane_b_data,
	output logic      [1:0]        lane_b_is_k,
	output logic                   lane_raw
);

////////////////////////////////////////////////////////////////////////////////
	localparam int ENTRY_W = 2 * LANE_W + 1;

	function automatic logic needs_8b10b(input logic [4:0] s);
		return s == TP_K28_5 || s == TP_ILA_LOOP || s == TP_RPAT ||
			s == TP_K28_7;
	endfunction
	function automatic logic [4:0] eff_mode(input logic [4:0] s,
		input logic enc8);
		logic [4:0] m;
		m = s;
		if (needs_8b10b(s) && !enc8) begin
			m = TP_NORMAL;
		end
		if (s == TP_RSVD || s > TP_K28_7) begin
			m = TP_NORMAL;
		end
		return m;
	endfunction
	// Taps as {order-1, tap-1}
	function automatic logic [9:0] prbs_taps(input logic [4:0] m);
		unique case (m)
			TP_PRBS7:  return {5'd6, 5'd5};
			TP_PRBS9:  return {5'd8, 5'd4};
			TP_PRBS15: return {5'd14, 5'd13};
			TP_PRBS23: return {5'd22, 5'd17};
			default:   return {5'd30, 5'd27};
		endcase
	endfunction
	function automatic logic [LFSR_W-1:0] prbs_adv(
		input logic [LFSR_W-1:0] s, input logic [9:0] tp);
		logic [LFSR_W-1:0] t;
		logic fb;
		t = s;
		for (int i = 0; i < WORD_W; i++) begin
			fb = t[tp[9:5]] ^ t[tp[4:0]];
			t = {t[LFSR_W-2:0], fb};
		end
		return t;
	endfunction
	// One alignment word: {k_hi, k_lo, hi octet, lo octet}
	function automatic logic [LANE_W-1:0] ila_word(input logic [3:0] c,
		input logic [7:0] id);
		logic [LANE_W-1:0] w;
		w = {2'b00, OCT_ZERO, OCT_ZERO};
		if (c[1:0] == 2'h0) begin
			w[17] = 1'b1;
			w[15:8] = K28_0;
			if (c[3:2] == ILA_ID_MF) begin
				w[16] = 1'b1;
				w[7:0] = K28_4;
			end
		end
		if (c[3:2] == ILA_ID_MF && c[1:0] == ILA_ID_W) begin
			w[15:8] = id;
		end
		if (c[1:0] == ILA_LAST_W) begin
			w[16] = 1'b1;
			w[7:0] = K28_3;
		end
		return w;
	endfunction
	function automatic logic [7:0] comma_char(input logic [1:0] s);
		unique case (s)
			FC_K28_1: return K28_1;
			FC_K28_5: return K28_5;
			default:  return K28_7;
		endcase
	endfunction
////////////////////////////////////////////////////////////////////////////////
// Registers and APB
	logic [REG_W-1:0]  test_pattern_select;
	logic [REG_W-1:0]  lane_alignment_identifier;
	logic [REG_W-1:0]  frame_comma_select;
	logic              addr_hit;
	logic              wr_fire;
	logic [REG_W-1:0]  next_rdata;

	assign addr_hit = paddr == ADDR_TEST || paddr == ADDR_IDENT ||
		paddr == ADDR_COMMA;
	// Zero-wait slave; a frozen clock enable stalls the bus
	assign pready  = ce;
	assign pslverr = psel && penable && !addr_hit;
	assign wr_fire = ce && psel && penable && pwrite && addr_hit;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			test_pattern_select       <= RST_TEST;
			lane_alignment_identifier <= RST_IDENT;
			frame_comma_select        <= RST_COMMA;
		end else if (wr_fire) begin
			unique case (paddr)
				ADDR_TEST:  test_pattern_select <= pwdata[REG_W-1:0];
				ADDR_IDENT: lane_alignment_identifier <=
					{pwdata[REG_W-1:1], 1'b0};
				default:    frame_comma_select <= pwdata[REG_W-1:0];
			endcase
		end
	end

	always_comb begin
		unique case (paddr)
			ADDR_TEST:  next_rdata = test_pattern_select;
			ADDR_IDENT: next_rdata = lane_alignment_identifier;
			ADDR_COMMA: next_rdata = frame_comma_select;
			default:    next_rdata = 8'h00;
		endcase
	end

	// Read data latched in the setup cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata <= '0;
		end else if (ce && psel && !penable) begin
			prdata <= {{(DATA_W-REG_W){1'b0}}, next_rdata};
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Link state and pattern generation
	link_state_t       state;
	logic [4:0]        mode;
	logic [7:0]        count;
	logic [LFSR_W-1:0] lfsr;
	logic [7:0]        last_octet;
	logic [7:0]        ident_b;
	logic              buf_in_ready;
	logic              gen_valid;
	logic              gen_fire;
	logic              take_sample;
	logic [LANE_W-1:0] gen_a;
	logic [LANE_W-1:0] gen_b;
	logic              gen_raw;

	assign mode = eff_mode(test_pattern_select[TEST_SEL_W-1:0], enc_8b10b);
	assign ident_b = lane_alignment_identifier + 8'h01;
	assign take_sample = state == st_run && mode == TP_NORMAL;
	assign gen_valid = ce && state != st_off &&
		(!take_sample || sample_valid);
	assign gen_fire = gen_valid && buf_in_ready;
	assign sample_ready = ce && buf_in_ready && take_sample;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= st_off;
		end else if (ce) begin
			unique case (state)
				st_off:
					if (link_enable) begin
						state <= enc_8b10b ? st_ila : st_run;
					end
				st_ila:
					if (!link_enable) begin
						state <= st_off;
					end else if (gen_fire && count[3:0] == ILA_END) begin
						state <= st_run;
					end
				st_run:
					if (!link_enable) begin
						state <= st_off;
					end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count <= '0;
		end else if (ce) begin
			if (state == st_off) begin
				count <= '0;
			end else if (gen_fire) begin
				count <= count + 8'h01;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lfsr <= LFSR_SEED;
		end else if (ce) begin
			if (state == st_off) begin
				lfsr <= LFSR_SEED;
			end else if (gen_fire) begin
				lfsr <= prbs_adv(lfsr, prbs_taps(mode));
			end
		end
	end
	// Previous frame-end octet for comma substitution
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			last_octet <= OCT_ZERO;
		end else if (ce && sample_ready && sample_valid &&
			sample_frame_end) begin
			last_octet <= sample_data[7:0];
		end
	end

	always_comb begin
		gen_raw = 1'b0;
		gen_a = {2'b00, sample_data};
		unique case (mode)
			TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23, TP_PRBS31: begin
				gen_raw = 1'b1;
				gen_a = {2'b00, lfsr[WORD_W-1:0]};
			end
			TP_RAMP:      gen_a = {2'b00, count, count + 8'h01};
			TP_TRANSPORT: gen_a = {2'b00, count, ~count};
			TP_D21_5:     gen_a = {2'b00, D21_5, D21_5};
			TP_K28_5:     gen_a = {2'b11, K28_5, K28_5};
			TP_ILA_LOOP:  gen_a = ila_word(count[3:0],
				lane_alignment_identifier);
			TP_RPAT:      gen_a = {2'b00, RPAT_SEQ[count[1:0]]};
			TP_LOW: begin
				gen_raw = 1'b1;
				gen_a = {2'b00, WORD_LOW};
			end
			TP_HIGH: begin
				gen_raw = 1'b1;
				gen_a = {2'b00, WORD_HIGH};
			end
			TP_CLOCK: begin
				gen_raw = 1'b1;
				gen_a = {2'b00, CLOCK_WORD};
			end
			TP_K28_7:     gen_a = {2'b11, K28_7, K28_7};
			default: begin
				if (state == st_ila) begin
					gen_a = ila_word(count[3:0],
						lane_alignment_identifier);
				end else if (enc_8b10b && sample_frame_end &&
					sample_data[7:0] == last_octet) begin
					// Only a repeated octet is swapped, so data survives
					gen_a[16] = 1'b1;
					gen_a[7:0] = comma_char(frame_comma_select[COMMA_W-1:0]);
				end
			end
		endcase
		gen_b = gen_a;
		if (state == st_ila || mode == TP_ILA_LOOP) begin
			gen_b = ila_word(count[3:0], ident_b);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer towards the serializers
	logic [ENTRY_W-1:0] buf_mem [BUF_DEPTH];
	logic               wr_ptr;
	logic               rd_ptr;
	logic [1:0]         fill;
	logic               pop;
	logic [ENTRY_W-1:0] head;

	assign buf_in_ready = fill != 2'(BUF_DEPTH);
	assign lane_valid = ce && fill != 2'h0;
	assign pop = ce && lane_valid && lane_ready;
	assign head = buf_mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (gen_fire) begin
			buf_mem[wr_ptr] <= {gen_raw, gen_b, gen_a};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fill <= 2'h0;
		end else begin
			if (gen_fire) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (gen_fire && !pop) begin
				fill <= fill + 2'h1;
			end else if (pop && !gen_fire) begin
				fill <= fill - 2'h1;
			end
		end
	end

	assign lane_a_data = head[WORD_W-1:0];
	assign lane_a_is_k = head[LANE_W-1:WORD_W];
	assign lane_b_data = head[LANE_W+WORD_W-1:LANE_W];
	assign lane_b_is_k = head[2*LANE_W-1:LANE_W+WORD_W];
	assign lane_raw    = head[ENTRY_W-1] && lane_valid;
endmodule

/* sim/link_test_framing_checker.sv */
// Port-level assertions for the link test and framing block
module link_test_framing_checker
	import link_cfg_pkg::*;
(
	// Clock, reset and register bus
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic              ce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	// Link control and lane head
	input wire logic              link_enable,
	input wire logic              enc_8b10b,
	input wire logic              lane_valid,
	input wire logic [WORD_W-1:0] lane_a_data,
	input wire logic [1:0]        lane_a_is_k,
	input wire logic [1:0]        lane_b_is_k
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [7:0] test_sh;
	logic [7:0] id_sh;
	logic [7:0] fc_sh;
	logic       wr;
	logic       rd;
	logic [7:0] comma_k;
	assign wr = psel && penable && pwrite && ce;
	assign rd = psel && penable && !pwrite;
	assign comma_k = fc_sh[1:0] == FC_K28_1 ? K28_1 :
		(fc_sh[1:0] == FC_K28_5 ? K28_5 : K28_7);
	////////////////////////////////////////////////////////////////////////
	// Shadow copies of the settings as software wrote them, identifier bit 0 cleared
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			test_sh <= 8'h00;
			id_sh <= 8'h00;
			fc_sh <= 8'h00;
		end else if (wr) begin
			if (paddr == ADDR_TEST)
				test_sh <= pwdata[7:0];
			if (paddr == ADDR_IDENT)
				id_sh <= {pwdata[7:1], 1'b0};
			if (paddr == ADDR_COMMA)
				fc_sh <= pwdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_test_read;
		rd && paddr == ADDR_TEST |-> prdata == {24'h0, test_sh};
	endproperty
	a_test_read: assert property (p_test_read)
		else $error("test select read-back differs");
	property p_id_read;
		rd && paddr == ADDR_IDENT |-> !prdata[0] && prdata[7:0] == id_sh;
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("identifier read-back differs");
	property p_fc_read;
		rd && paddr == ADDR_COMMA |-> prdata == {24'h0, fc_sh};
	endproperty
	a_fc_read: assert property (p_fc_read)
		else $error("comma select read-back differs");
	property p_low;
		lane_valid && link_enable && test_sh[4:0] == TP_LOW
			|-> lane_a_data == WORD_LOW;
	endproperty
	a_low: assert property (p_low)
		else $error("lane not held low");
	property p_clk;
		lane_valid && link_enable && test_sh[4:0] == TP_CLOCK
			|-> lane_a_data == CLOCK_WORD;
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock pattern wrong");
	property p_no_k;
		lane_valid && !enc_8b10b |-> lane_a_is_k == 2'b00 && lane_b_is_k == 2'b00;
	endproperty
	a_no_k: assert property (p_no_k)
		else $error("control character in 64b/66b mode");
	property p_comma;
		lane_valid && lane_a_is_k == 2'b01 && fc_sh[1:0] != 2'h3 &&
			test_sh[4:0] == TP_NORMAL && lane_a_data[7:0] != K28_3 &&
			lane_a_data[7:0] != K28_4 |-> enc_8b10b && lane_a_data[7:0] == comma_k;
	endproperty
	a_comma: assert property (p_comma)
		else $error("wrong frame comma");
	property p_ila_start;
		$rose(link_enable) && enc_8b10b && ce && !lane_valid &&
			test_sh[4:0] == TP_NORMAL
			|-> ##[1:3] (lane_valid && lane_a_data[15:8] == K28_0);
	endproperty
	a_ila_start: assert property (p_ila_start)
		else $error("alignment sequence did not start");
endmodule

/* sim/link_receiver.sv */
// Receiver model that takes lane words from both links
module link_receiver
	import link_cfg_pkg::*;
(
	// Lane side
	input wire logic              clock,
	input wire logic              lane_valid,
	output logic                  lane_ready,
	input wire logic [WORD_W-1:0] a_data,
	input wire logic [1:0]        a_k,
	input wire logic [WORD_W-1:0] b_data,
	input wire logic [1:0]        b_k,
	input wire logic              raw,
	// Bench control: stall holds ready low
	input wire logic              stall
);
	logic [36:0] q[$];
	assign lane_ready = !stall;
	always @(posedge clock) begin
		if (lane_valid && lane_ready)
			q.push_back({raw, b_k, b_data, a_k, a_data});
	end
endmodule

/* sim/link_test_framing_test.sv */
// Self-checking bench for the link test and framing block
module link_test_framing_test
	import link_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, sys_rst, ce, psel, penable, pwrite, link_enable, enc_8b10b;
	logic sample_valid, sample_frame_end, stall, took, e;
	logic pready, pslverr, sample_ready, lane_valid, lane_ready, lane_raw;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r;
	logic [WORD_W-1:0] sample_data, a_d, b_d;
	logic [1:0]        a_k, b_k;
	logic [36:0]       w;
	int                bad_count, n_compared, n;
	logic [13:0] adr[3] = '{ADDR_TEST, ADDR_IDENT, ADDR_COMMA};
	logic [7:0]  cm[3] = '{K28_7, K28_1, K28_5};
	logic [4:0]  tp[10] = '{TP_LOW, TP_HIGH, TP_CLOCK, TP_D21_5, TP_K28_5,
		TP_K28_7, TP_RAMP, TP_TRANSPORT, TP_RPAT, TP_ILA_LOOP};
	// Fourth word of each pattern, so counter-driven ones show word 3
	logic [17:0] ex[10] = '{{2'b00, WORD_LOW}, {2'b00, WORD_HIGH},
		{2'b00, CLOCK_WORD}, {2'b00, D21_5, D21_5}, {2'b11, K28_5, K28_5},
		{2'b11, K28_7, K28_7}, 18'h00304, 18'h003fc,
		{2'b00, RPAT_SEQ[3]}, {2'b01, OCT_ZERO, K28_3}};

	link_test_framing i_dut (
		.clock(clock), .sys_rst(sys_rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_enable(link_enable), .enc_8b10b(enc_8b10b),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_data(sample_data), .sample_frame_end(sample_frame_end),
		.lane_valid(lane_valid), .lane_ready(lane_ready),
		.lane_a_data(a_d), .lane_a_is_k(a_k), .lane_b_data(b_d),
		.lane_b_is_k(b_k), .lane_raw(lane_raw));
	link_receiver i_rx (
		.clock(clock), .lane_valid(lane_valid), .lane_ready(lane_ready),
		.a_data(a_d), .a_k(a_k), .b_data(b_d), .b_k(b_k), .raw(lane_raw),
		.stall(stall));

	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	task give_verdict();
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	task apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (n == 50) begin
			chk("pready", 1, 0);
			give_verdict();
		end else begin
			r = prdata;
			e = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	// Refusal is legal here, so took is left for the caller to judge
	task push(input logic [15:0] d, input logic fe);
		@(posedge clock);
		sample_valid <= 1;
		sample_data <= d;
		sample_frame_end <= fe;
		took = 0;
		for (n = 0; n < 8 && !took; n++) begin
			@(posedge clock);
			took = sample_ready === 1'b1;
		end
		sample_valid <= 0;
	endtask
	task pop();
		for (n = 0; n < 200 && i_rx.q.size() == 0; n++)
			@(posedge clock);
		if (i_rx.q.size() == 0) begin
			chk("lane word", 1, 0);
			give_verdict();
		end else begin
			w = i_rx.q.pop_front();
		end
	endtask
	task start(input logic [31:0] sel, input logic [31:0] fc, input logic enc);
		link_enable <= 0;
		apb(1, ADDR_TEST, sel);
		apb(1, ADDR_COMMA, fc);
		enc_8b10b <= enc;
		@(posedge clock);
		i_rx.q.delete();
		link_enable <= 1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, ce, psel, penable, pwrite, link_enable, enc_8b10b} = 7'h60;
		{sample_valid, sample_frame_end, stall} = 3'h0;
		{paddr, pwdata, sample_data} = '0;
		repeat (16) @(posedge clock);
		sys_rst <= 0;
		for (int i = 0; i < 3; i++) begin
			apb(0, adr[i], 0);
			chk("reset value", 0, r);
			chk("no error", 0, e);
		end
		apb(0, 14'h0820, 32'h5);
		chk("unmapped error", 1, e);
		chk("unmapped read", 0, r);
		apb(1, ADDR_IDENT, 32'hffff_ff35);
		apb(0, ADDR_IDENT, 0);
		chk("identifier", 32'h34, r);
		apb(1, ADDR_TEST, 32'h1e3);
		apb(1, ADDR_COMMA, 32'hfd);
		apb(0, ADDR_TEST, 0);
		chk("test select", 32'he3, r);
		apb(0, ADDR_COMMA, 0);
		chk("comma select", 32'hfd, r);
		start(TP_NORMAL, 0, 1);
		for (int i = 0; i < 16; i++) begin
			pop();
			if (i == 0)
				chk("alignment start", K28_0, w[15:8]);
			if (i == 5)
				chk("identifier a", 8'h34, w[15:8]);
			if (i == 5)
				chk("identifier b", 8'h35, w[33:26]);
		end
		// Compliant pick 0 first, then the generic receiver picks 1 and 2
		for (int c = 0; c < 3; c++) begin
			start(TP_NORMAL, c, 1);
			repeat (16) pop();
			stall <= 1;
			push(16'h1155, 1);
			chk("sample taken", 1, took);
			push(16'h2255, 1);
			chk("sample taken", 1, took);
			push(16'h3355, 1);
			chk("full buffer refuses", 0, took);
			stall <= 0;
			pop();
			pop();
			chk("comma", {2'b01, 8'h22, cm[c]}, w[17:0]);
		end
		for (int i = 0; i < 10; i++) begin
			start(tp[i], 0, 1);
			repeat (4) pop();
			chk("pattern", ex[i], w[17:0] & {i > 2 ? 2'b11 : 2'b00,
				16'hffff});
			chk("raw line", i < 3, w[36]);
		end
		// Frozen block stalls the bus and offers no lane word
		ce <= 0;
		@(posedge clock);
		chk("pready frozen", 0, pready);
		chk("lane frozen", 0, lane_valid);
		ce <= 1;
		// Reserved select and an 8b/10b-only select both give plain data
		for (int i = 0; i < 2; i++) begin
			start(i ? 32'(TP_K28_5) : 32'd12, 0, 0);
			push(16'h1234, 0);
			chk("sample taken", 1, took);
			pop();
			chk("plain data", {2'b00, 16'h1234}, w[17:0]);
		end
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
endmodule

bind link_test_framing link_test_framing_checker i_chk (
	.clock(clock), .sys_rst(sys_rst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .link_enable(link_enable), .enc_8b10b(enc_8b10b),
	.lane_valid(lane_valid), .lane_a_data(lane_a_data),
	.lane_a_is_k(lane_a_is_k), .lane_b_is_k(lane_b_is_k));
